/* File: core/tmr_pkg.sv */
// Package for the 16-bit peripheral timer block: file addresses, fields, resets.
// Assumes an 8-bit file-register port from the CPU with separate read and write strobes.
package tmr_pkg;
  // ----------------------------------------
  // File addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_INT_CTRL = 8'h0B;
  localparam logic [7:0] ADDR_INT_CTRL_B1 = 8'h8B;
  localparam logic [7:0] ADDR_PIR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h0E;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h0F;
  localparam logic [7:0] ADDR_TMR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_PIR_ENABLES = 8'h8C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int OVF_BIT = 0;
  localparam int CMP_BIT = 3;
  localparam int ADC_BIT = 6;
  localparam int EE_BIT = 7;
  localparam int GATE_EN_BIT = 6;
  localparam int PRESC_LSB = 4;
  localparam int OSC_EN_BIT = 3;
  localparam int SYNC_DIS_BIT = 2;
  localparam int SRC_SEL_BIT = 1;
  localparam int RUN_BIT = 0;
  // ----------------------------------------
  // Masks and reset values
  // ----------------------------------------
  localparam logic [7:0] FLAG_MASK = 8'hC9;
  localparam logic [7:0] TMR_CTRL_MASK = 8'h7F;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ENABLES_RST = 8'h00;
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // Instruction clock is the oscillator divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
endpackage

/* File: core/tmr_timer_core.sv */
// Timer block: 16-bit counter, control register, peripheral flags and enables.
// Assumes CPU strobes and pins are synchronous to i_ref_clk (the oscillator).
`timescale 1ns/100ps
`default_nettype none
module tmr_timer_core
  import tmr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_ext_clk_pin,
  input wire logic i_gate_pin,
  input wire logic i_eeprom_done,
  input wire logic i_conv_done,
  input wire logic i_cmp_change,
  output logic o_irq,
  output logic o_low_power_osc_enable
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] int_ctrl_r;
  logic [7:0] flags_r;
  logic [7:0] enables_r;
  logic [7:0] tmr_ctrl_r;
  logic [15:0] count_r;
  logic [1:0] instr_div_r;
  logic [2:0] presc_r;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_raw_prev_r;
  logic [7:0] rdata_nxt;
  logic src_tick;
  logic presc_tick;
  logic count_en;
  logic overflow;

  // ----------------------------------------
  // Clock source and prescaler
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
      ext_raw_prev_r <= 1'b0;
    end
    else
    begin
      ext_meta_r <= i_ext_clk_pin;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
      ext_raw_prev_r <= i_ext_clk_pin;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      instr_div_r <= 2'h0;
    else
      instr_div_r <= instr_div_r + 2'h1;
  end

  // Unsynchronised path samples the pin directly; two cycles less latency, no metastability cover
  always_comb
  begin
    if (!tmr_ctrl_r[SRC_SEL_BIT])
      src_tick = (instr_div_r == INSTR_LAST);
    else if (tmr_ctrl_r[SYNC_DIS_BIT])
      src_tick = i_ext_clk_pin & ~ext_raw_prev_r;
    else
      src_tick = ext_sync_r & ~ext_prev_r;
  end

  assign count_en = tmr_ctrl_r[RUN_BIT] &
                    (~tmr_ctrl_r[GATE_EN_BIT] | ~i_gate_pin);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      presc_r <= 3'h0;
    else if (src_tick && count_en)
      presc_r <= presc_r + 3'h1;
  end

  always_comb
  begin
    unique case (tmr_ctrl_r[PRESC_LSB +: 2])
      2'h0: presc_tick = 1'b1;
      2'h1: presc_tick = presc_r[0];
      2'h2: presc_tick = &presc_r[1:0];
      2'h3: presc_tick = &presc_r;
    endcase
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  assign overflow = src_tick && count_en && presc_tick && (count_r == 16'hFFFF);

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      count_r <= COUNT_RST;
    else if (i_wr && i_addr == ADDR_CNT_LOW)
      count_r[7:0] <= i_wdata;
    else if (i_wr && i_addr == ADDR_CNT_HIGH)
      count_r[15:8] <= i_wdata;
    else if (src_tick && count_en && presc_tick)
      count_r <= count_r + 16'h0001;
  end

  // ----------------------------------------
  // Control, flags and enables
  // ----------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      tmr_ctrl_r <= TMR_CTRL_RST;
    else if (i_wr && i_addr == ADDR_TMR_CTRL)
      tmr_ctrl_r <= i_wdata & TMR_CTRL_MASK;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      int_ctrl_r <= INT_CTRL_RST;
    else if (i_wr && (i_addr == ADDR_INT_CTRL || i_addr == ADDR_INT_CTRL_B1))
      int_ctrl_r <= i_wdata;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      enables_r <= ENABLES_RST;
    else if (i_wr && i_addr == ADDR_PIR_ENABLES)
      enables_r <= i_wdata & FLAG_MASK;
  end

  // Event set wins over a software clear in the same cycle
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      flags_r <= FLAGS_RST;
    else
    begin
      if (i_wr && i_addr == ADDR_PIR_FLAGS)
        flags_r <= (i_wdata & FLAG_MASK)
                   | ({7'h00, overflow} << OVF_BIT)
                   | ({7'h00, i_cmp_change} << CMP_BIT)
                   | ({7'h00, i_conv_done} << ADC_BIT)
                   | ({7'h00, i_eeprom_done} << EE_BIT);
      else
      begin
        if (overflow)
          flags_r[OVF_BIT] <= 1'b1;
        if (i_cmp_change)
          flags_r[CMP_BIT] <= 1'b1;
        if (i_conv_done)
          flags_r[ADC_BIT] <= 1'b1;
        if (i_eeprom_done)
          flags_r[EE_BIT] <= 1'b1;
      end
    end
  end

  // The core saves only the return PC; this request carries no context
  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_irq <= 1'b0;
    else
      o_irq <= int_ctrl_r[GLOBAL_EN_BIT] & int_ctrl_r[PERIPH_EN_BIT]
               & |(flags_r & enables_r);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_low_power_osc_enable <= 1'b0;
    else
      o_low_power_osc_enable <= tmr_ctrl_r[OSC_EN_BIT];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb
  begin
    unique case (i_addr)
      ADDR_INT_CTRL, ADDR_INT_CTRL_B1: rdata_nxt = int_ctrl_r;
      ADDR_PIR_FLAGS: rdata_nxt = flags_r & FLAG_MASK;
      ADDR_PIR_ENABLES: rdata_nxt = enables_r;
      ADDR_CNT_LOW: rdata_nxt = count_r[7:0];
      ADDR_CNT_HIGH: rdata_nxt = count_r[15:8];
      ADDR_TMR_CTRL: rdata_nxt = tmr_ctrl_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rdata_nxt;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_ovf_sets_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    overflow |=> flags_r[OVF_BIT])
    else $error("overflow did not set flag");
  a_flag_holds: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    flags_r[OVF_BIT] && !(i_wr && i_addr == ADDR_PIR_FLAGS) |=> flags_r[OVF_BIT])
    else $error("overflow flag dropped without a write");
  a_no_run_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !tmr_ctrl_r[RUN_BIT] && !(i_wr && (i_addr == ADDR_CNT_LOW || i_addr == ADDR_CNT_HIGH))
      |=> $stable(count_r))
    else $error("counter moved while stopped");
  a_gate_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    tmr_ctrl_r[GATE_EN_BIT] && i_gate_pin && !i_wr |=> $stable(count_r))
    else $error("counter moved with gate high");
  a_int_rate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !tmr_ctrl_r[SRC_SEL_BIT] && src_tick |=> !src_tick [*3])
    else $error("internal tick faster than divide by four");
  a_unimpl_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (flags_r & ~FLAG_MASK) == 8'h00 && (enables_r & ~FLAG_MASK) == 8'h00)
    else $error("unimplemented flag bit set");
  a_event_flags: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    i_cmp_change |=> flags_r[CMP_BIT])
    else $error("comparator flag not set");
  a_irq_gated: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    !int_ctrl_r[GLOBAL_EN_BIT] |=> !o_irq)
    else $error("request without global enable");
  a_presc_div8: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    tmr_ctrl_r[PRESC_LSB +: 2] == 2'h3 && src_tick && presc_r == 3'h0 |-> !presc_tick)
    else $error("divide by eight ticked early");
  c_overflow: cover property (@(posedge i_ref_clk) overflow);
  c_irq: cover property (@(posedge i_ref_clk) o_irq);
  c_ext_sync: cover property (@(posedge i_ref_clk)
    tmr_ctrl_r[SRC_SEL_BIT] && !tmr_ctrl_r[SYNC_DIS_BIT] && src_tick);
endmodule // tmr_timer_core
`default_nettype wire

/* File: test/tmr_pin_model.sv */
// Pin model: bursts of external timer clock edges and the gate pin level.
// Assumes the bench asks for a burst only while none is running.
`timescale 1ns/100ps
`default_nettype none
module tmr_pin_model (
  input wire logic i_ref_clk,
  input wire logic i_go,
  input wire logic [7:0] i_edges,
  input wire logic i_gate,
  output logic o_ext_clk,
  output logic o_gate,
  output logic o_busy
);
  logic [7:0] left_r = 8'h00;
  logic [2:0] ph_r = 3'h0;
  // Eight-cycle edges so the synchronised path cannot miss one
  always_ff @(posedge i_ref_clk)
  begin
    ph_r <= ph_r + 3'h1;
    if (i_go)
    begin
      left_r <= i_edges;
      ph_r <= 3'h0;
    end
    else if (ph_r == 3'h7 && left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  // Clock stands low between bursts
  assign o_ext_clk = (left_r != 8'h00) && ph_r[2];
  assign o_gate = i_gate;
  assign o_busy = left_r != 8'h00;
endmodule // tmr_pin_model
`default_nettype wire

/* File: test/tb.sv */
// Self-checking bench for the timer block through its file-register port.
// Assumes the pin model drives the external clock and gate pins.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import tmr_pkg::*;
  logic clk, rst, wr, rd, ext, gate, gsel, ee, cv, cm, irq, lpo, go, busy;
  logic [7:0] addr, wd, rdat, ned;
  int fails, samples_checked;
  tmr_timer_core tmr_timer_core_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_addr(addr), .i_wr(wr), .i_wdata(wd), .i_rd(rd), .o_rdata(rdat),
    .i_ext_clk_pin(ext), .i_gate_pin(gate), .i_eeprom_done(ee),
    .i_conv_done(cv), .i_cmp_change(cm), .o_irq(irq),
    .o_low_power_osc_enable(lpo));
  tmr_pin_model tmr_pin_model_inst (.i_ref_clk(clk), .i_go(go),
    .i_edges(ned), .i_gate(gsel), .o_ext_clk(ext), .o_gate(gate),
    .o_busy(busy));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ----------------------------------------
  // Port tasks
  // ----------------------------------------
  task automatic end_sim();
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
    rd8(a);
    chk(n, e, rdat);
  endtask
  // Counts from zero for n cycles, or for n external edges; the free
  // running divider phase allows one count either way
  task automatic run(input logic [7:0] c, input int n, input int e, input logic x);
    wr8(ADDR_CNT_LOW, 8'h00);
    wr8(ADDR_CNT_HIGH, 8'h00);
    wr8(ADDR_TMR_CTRL, c);
    if (x)
    begin
      ned = 8'(n);
      go = 1'b1;
      @(posedge clk);
      #1;
      go = 1'b0;
      // Look after the edge so the burst flag is settled
      for (int i = 0; i < 600 && busy; i++)
      begin
        @(posedge clk);
        #1;
      end
      if (busy)
      begin
        fails++;
        $display("MISMATCH pin_burst exp idle got busy");
        end_sim();
      end
      repeat (8) @(posedge clk);
    end
    else
      repeat (n) @(posedge clk);
    wr8(ADDR_TMR_CTRL, 8'h00);
    rchk("count_high", ADDR_CNT_HIGH, 8'h00);
    rd8(ADDR_CNT_LOW);
    samples_checked++;
    if (int'(rdat) < e - 1 || int'(rdat) > e + 1 || (x && int'(rdat) != e))
    begin
      fails++;
      $display("MISMATCH count c=%h exp %0d got %h", c, e, rdat);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {rst, wr, rd, gsel, ee, cv, cm, go} = 8'h80;
    addr = 8'h00;
    wd = 8'h00;
    ned = 8'h00;
    fails = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    rchk("int_ctrl", ADDR_INT_CTRL, 8'h00);
    rchk("flags", ADDR_PIR_FLAGS, 8'h00);
    rchk("enables", ADDR_PIR_ENABLES, 8'h00);
    rchk("tmr_ctrl", ADDR_TMR_CTRL, 8'h00);
    rchk("unmapped", 8'h20, 8'h00);
    @(posedge clk);
    #1;
    {ee, cv, cm} = 3'h7;
    @(posedge clk);
    #1;
    {ee, cv, cm} = 3'h0;
    rchk("flags", ADDR_PIR_FLAGS, 8'hC8);
    chk("irq", 8'h00, {7'h00, irq});
    wr8(ADDR_PIR_FLAGS, 8'hFF);
    rchk("flags", ADDR_PIR_FLAGS, 8'hC9);
    wr8(ADDR_PIR_FLAGS, 8'h00);
    rchk("flags", ADDR_PIR_FLAGS, 8'h00);
    wr8(ADDR_PIR_ENABLES, 8'hFF);
    rchk("enables", ADDR_PIR_ENABLES, 8'hC9);
    wr8(ADDR_TMR_CTRL, 8'hFE);
    rchk("tmr_ctrl", ADDR_TMR_CTRL, 8'h7E);
    chk("lpo", 8'h01, {7'h00, lpo});
    for (int p = 0; p < 4; p++)
      run(8'(p * 16 + 1), 256, 64 >> p, 1'b0);
    run(8'h05, 256, 64, 1'b0);
    gsel = 1'b1;
    run(8'h41, 256, 0, 1'b0);
    run(8'h01, 256, 64, 1'b0);
    gsel = 1'b0;
    run(8'h41, 256, 64, 1'b0);
    run(8'h40, 256, 0, 1'b0);
    run(8'h03, 20, 20, 1'b1);
    run(8'h07, 20, 20, 1'b1);
    run(8'h13, 20, 10, 1'b1);
    wr8(ADDR_PIR_FLAGS, 8'h00);
    wr8(ADDR_PIR_ENABLES, 8'h01);
    wr8(ADDR_INT_CTRL_B1, 8'hC0);
    rchk("int_ctrl", ADDR_INT_CTRL, 8'hC0);
    wr8(ADDR_CNT_LOW, 8'hFE);
    wr8(ADDR_CNT_HIGH, 8'hFF);
    wr8(ADDR_TMR_CTRL, 8'h01);
    for (int i = 0; i < 100 && irq !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (irq !== 1'b1)
    begin
      fails++;
      $display("MISMATCH irq exp 1 got %b", irq);
      end_sim();
    end
    wr8(ADDR_TMR_CTRL, 8'h00);
    rchk("flags", ADDR_PIR_FLAGS, 8'h01);
    rchk("count_high", ADDR_CNT_HIGH, 8'h00);
    wr8(ADDR_INT_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk("irq", 8'h00, {7'h00, irq});
    rchk("flags", ADDR_PIR_FLAGS, 8'h01);
    wr8(ADDR_PIR_FLAGS, 8'h00);
    rchk("flags", ADDR_PIR_FLAGS, 8'h00);
    chk("lpo", 8'h00, {7'h00, lpo});
    end_sim();
  end
endmodule // tb
`default_nettype wire
